// ===== src/sasq_consts.vh
// constants and register map of the converter sequencer
`ifndef SASQ_CONSTS_VH
`define SASQ_CONSTS_VH
`define SASQ_A_MODE 3'h0
`define SASQ_A_CHAN 3'h1
`define SASQ_A_PFMODE 3'h2
`define SASQ_A_THRESH 3'h3
`define SASQ_A_RES_LO 3'h4
`define SASQ_A_RES_HI 3'h5
`define SASQ_A_STATUS 3'h6
`define SASQ_MODE_START 7
`define SASQ_MODE_REFEN 0
`define SASQ_MODE_FR_HI 5
`define SASQ_MODE_FR_LO 3
`define SASQ_PF_EN 7
`define SASQ_PF_SENSE 6
`define SASQ_RST8 8'h00
`define SASQ_MSB 4'h9
`define SASQ_LJ_SHIFT 6
`define SASQ_FIRST_EXTRA 16'h0020
`define SASQ_SETTLE_NS 14000
`define SASQ_CLK_NS 40
`endif

// ===== src/sasq_timer.v
// conversion time divider: one trial tick per bit period
`timescale 1ns/1ps
module sasq_timer #(
    parameter W = 16
) (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_clear,
    input wire [W-1:0] i_period,
    output reg o_tick
);
    reg [W-1:0] cnt_ff;
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            cnt_ff <= {W{1'b0}};
            o_tick <= 1'b0;
        end else if (i_clear) begin
            cnt_ff <= {W{1'b0}};
            o_tick <= 1'b0;
        end else if (cnt_ff >= i_period) begin
            cnt_ff <= {W{1'b0}};
            o_tick <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff + {{(W-1){1'b0}}, 1'b1};
            o_tick <= 1'b0;
        end
    end
endmodule // sasq_timer

// ===== src/sasq_sync.v
// two-flop synchroniser for the comparator level
`timescale 1ns/1ps
module sasq_sync (
    input wire i_mclk,
    input wire i_arst_n,
    input wire i_d,
    output reg o_q
);
    reg meta_ff;
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            meta_ff <= 1'b0;
            o_q <= 1'b0;
        end else begin
            meta_ff <= i_d;
            o_q <= meta_ff;
        end
    end
endmodule // sasq_sync

// ===== src/sasq_top.v
// successive-approximation sequencer with power-fail compare
//
// Chosen here: the address-and-strobe port and the address map.
`timescale 1ns/1ps
`include "sasq_consts.vh"
module sasq_top #(
    parameter SAMPLE_TICKS = 4,
    parameter TW = 16
) (
    input wire i_mclk,
    input wire i_arst_n,
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire i_cmp_ge,
    output reg [7:0] o_rdata,
    output reg o_sample,
    output reg o_hold,
    output reg [9:0] o_tap,
    output reg [1:0] o_chan,
    output reg o_ref_en,
    output reg o_conversion_end_irq
);
    // ------------------------------------------------------------
    // state codes
    // ------------------------------------------------------------
    localparam ST_IDLE = 2'b00;
    localparam ST_SAMP = 2'b01;
    localparam ST_TRIAL = 2'b10;

    reg [7:0] converter_mode_reg_ff;
    reg [1:0] input_select_reg_ff;
    reg [7:0] powerfail_mode_reg_ff;
    reg [7:0] threshold_reg_ff;
    reg [15:0] result_reg_ff;
    reg [9:0] approximation_reg_ff;
    reg [3:0] bit_ff;
    reg [1:0] st_ff;
    reg [3:0] samp_ff;
    reg first_ff;
    reg pend_ff;
    reg [9:0] pend_val_ff;
    reg pend_irq_ff;
    reg [TW-1:0] period;
    wire tick;
    wire cmp_s;
    wire wr_cfg;
    wire start;
    wire conv_done;
    wire irq_cond;
    wire rd_res;

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // bit period in clocks, less one, per code of the time field
    function [TW-1:0] fr_period;
        input [2:0] fr;
        begin
            case (fr)
                3'h0: fr_period = 16'h0018;
                3'h1: fr_period = 16'h0014;
                3'h2: fr_period = 16'h0010;
                3'h4: fr_period = 16'h000C;
                3'h5: fr_period = 16'h000A;
                3'h6: fr_period = 16'h0008;
                default: fr_period = 16'h0018;
            endcase
        end
    endfunction

    // one-hot mask for a bit index
    function [9:0] bit_mask;
        input [3:0] idx;
        begin
            bit_mask = 10'h001 << idx;
        end
    endfunction

    function pf_pass;
        input [7:0] powerfail_mode_reg;
        input [7:0] hi;
        input [7:0] thr;
        begin
            if (!powerfail_mode_reg[`SASQ_PF_EN])
                pf_pass = 1'b1;
            else if (powerfail_mode_reg[`SASQ_PF_SENSE])
                pf_pass = (hi < thr);
            else
                pf_pass = (hi >= thr);
        end
    endfunction

    sasq_sync u_sync (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_d(i_cmp_ge),
        .o_q(cmp_s)
    );

    // first conversion runs a longer bit period
    always @* begin
        period = fr_period(converter_mode_reg_ff[`SASQ_MODE_FR_HI:`SASQ_MODE_FR_LO]);
        if (first_ff)
            period = period + `SASQ_FIRST_EXTRA;
    end

    sasq_timer #(.W(TW)) u_timer (
        .i_mclk(i_mclk),
        .i_arst_n(i_arst_n),
        .i_clear(wr_cfg || st_ff == ST_IDLE),
        .i_period(period),
        .o_tick(tick)
    );

    // ------------------------------------------------------------
    // register writes
    // ------------------------------------------------------------
    // any configuration write aborts
    assign wr_cfg = i_wr && (i_addr == `SASQ_A_MODE || i_addr == `SASQ_A_CHAN ||
        i_addr == `SASQ_A_PFMODE || i_addr == `SASQ_A_THRESH);
    assign start = converter_mode_reg_ff[`SASQ_MODE_START];
    // config write at the final tick suppresses the result
    assign conv_done = (st_ff == ST_TRIAL) && tick && (bit_ff == 4'h0) && !wr_cfg;
    assign rd_res = i_rd && (i_addr == `SASQ_A_RES_LO || i_addr == `SASQ_A_RES_HI);

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            converter_mode_reg_ff <= `SASQ_RST8;
            input_select_reg_ff <= 2'h0;
            powerfail_mode_reg_ff <= `SASQ_RST8;
            threshold_reg_ff <= `SASQ_RST8;
        end else if (i_wr) begin
            if (i_addr == `SASQ_A_MODE)
                converter_mode_reg_ff <= i_wdata;
            else if (i_addr == `SASQ_A_CHAN)
                // channel write is a config write: it aborts and can suppress the irq
                input_select_reg_ff <= i_wdata[1:0];
            else if (i_addr == `SASQ_A_PFMODE)
                powerfail_mode_reg_ff <= {i_wdata[7:6], 6'h00};
            else if (i_addr == `SASQ_A_THRESH)
                threshold_reg_ff <= i_wdata;
        end
    end

    // ------------------------------------------------------------
    // conversion sequence
    // ------------------------------------------------------------
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            st_ff <= ST_IDLE;
            approximation_reg_ff <= 10'h000;
            bit_ff <= `SASQ_MSB;
            samp_ff <= 4'h0;
            first_ff <= 1'b1;
        end else if (!start || (wr_cfg && i_addr == `SASQ_A_MODE &&
                     !i_wdata[`SASQ_MODE_START])) begin
            st_ff <= ST_IDLE;
            first_ff <= 1'b1;
        end else if (wr_cfg) begin
            st_ff <= ST_SAMP;
            samp_ff <= 4'h0;
        end else begin
            case (st_ff)
                ST_IDLE: begin
                    st_ff <= ST_SAMP;
                    samp_ff <= 4'h0;
                end
                ST_SAMP: begin
                    if (tick) begin
                        if (samp_ff == SAMPLE_TICKS - 1) begin
                            st_ff <= ST_TRIAL;
                            bit_ff <= `SASQ_MSB;
                            approximation_reg_ff <= bit_mask(`SASQ_MSB);
                        end else begin
                            samp_ff <= samp_ff + 4'h1;
                        end
                    end
                end
                ST_TRIAL: begin
                    if (tick) begin
                        // keep bit when input at or above tap
                        if (bit_ff == 4'h0) begin
                            approximation_reg_ff <= cmp_s ? approximation_reg_ff :
                                (approximation_reg_ff & ~bit_mask(bit_ff));
                            st_ff <= ST_SAMP;
                            samp_ff <= 4'h0;
                            first_ff <= 1'b0;
                        end else begin
                            approximation_reg_ff <= (cmp_s ? approximation_reg_ff :
                                (approximation_reg_ff & ~bit_mask(bit_ff))) |
                                bit_mask(bit_ff - 4'h1);
                            bit_ff <= bit_ff - 4'h1;
                        end
                    end
                end
                default: st_ff <= ST_IDLE;
            endcase
        end
    end

    // ------------------------------------------------------------
    // result latch and interrupt
    // ------------------------------------------------------------
    wire [9:0] final_code = cmp_s ? approximation_reg_ff :
        (approximation_reg_ff & ~bit_mask(4'h0));
    assign irq_cond = pf_pass(powerfail_mode_reg_ff, final_code[9:2], threshold_reg_ff);

    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            result_reg_ff <= 16'h0000;
            pend_ff <= 1'b0;
            pend_val_ff <= 10'h000;
            pend_irq_ff <= 1'b0;
            o_conversion_end_irq <= 1'b0;
        end else begin
            o_conversion_end_irq <= 1'b0;
            if (conv_done && rd_res) begin
                pend_ff <= 1'b1;
                pend_val_ff <= final_code;
                pend_irq_ff <= irq_cond;
            end else if (conv_done) begin
                result_reg_ff <= {final_code, 6'h00};
                pend_ff <= 1'b0;
                o_conversion_end_irq <= irq_cond;
            end else if (pend_ff) begin
                result_reg_ff <= {pend_val_ff, 6'h00};
                pend_ff <= 1'b0;
                o_conversion_end_irq <= pend_irq_ff;
            end
        end
    end

    // ------------------------------------------------------------
    // analog side outputs and read port
    // ------------------------------------------------------------
    always @(posedge i_mclk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            o_sample <= 1'b0;
            o_hold <= 1'b0;
            o_tap <= 10'h000;
            o_chan <= 2'h0;
            o_ref_en <= 1'b0;
            o_rdata <= 8'h00;
        end else begin
            o_sample <= (st_ff == ST_SAMP);
            o_hold <= (st_ff == ST_TRIAL);
            o_tap <= approximation_reg_ff;
            o_chan <= input_select_reg_ff;
            o_ref_en <= converter_mode_reg_ff[`SASQ_MODE_REFEN];
            o_rdata <= 8'h00;
            if (i_rd) begin
                if (i_addr == `SASQ_A_MODE)
                    o_rdata <= converter_mode_reg_ff;
                else if (i_addr == `SASQ_A_CHAN)
                    o_rdata <= {6'h00, input_select_reg_ff};
                else if (i_addr == `SASQ_A_PFMODE)
                    o_rdata <= powerfail_mode_reg_ff;
                else if (i_addr == `SASQ_A_THRESH)
                    o_rdata <= threshold_reg_ff;
                else if (i_addr == `SASQ_A_RES_LO)
                    o_rdata <= result_reg_ff[7:0];
                else if (i_addr == `SASQ_A_RES_HI)
                    o_rdata <= result_reg_ff[15:8];
                else if (i_addr == `SASQ_A_STATUS)
                    o_rdata <= {5'h00, first_ff, st_ff};
            end
        end
    end
endmodule // sasq_top

// ===== verification/sasq_ana.sv
// comparator, tap and sample-hold model on the analog side
`timescale 1ns/1ps
module sasq_ana (
    input wire i_mclk,
    input wire i_sample,
    input wire i_hold,
    input wire [9:0] i_tap,
    input wire [1:0] i_chan,
    input wire [39:0] i_vin,
    output wire o_cmp_ge
);
    reg [9:0] held_ff = 10'h000;
    reg junk_ff = 1'b0;
    always @(posedge i_mclk) begin
        if (i_sample)
            held_ff <= i_vin[i_chan*10 +: 10];
        junk_ff <= !junk_ff;
    end
    // held level against tap
    // outside hold the comparator is meaningless, so it toggles
    assign o_cmp_ge = i_hold ? (held_ff >= i_tap) : junk_ff;
endmodule // sasq_ana

// ===== verification/sasq_chk.sv
// port checker for the converter sequencer
`timescale 1ns/1ps
module sasq_chk (
    input wire i_mclk,
    input wire i_arst_n,
    input wire [2:0] i_addr,
    input wire [7:0] i_wdata,
    input wire i_wr,
    input wire i_rd,
    input wire [7:0] o_rdata,
    input wire o_sample,
    input wire o_hold,
    input wire [9:0] o_tap,
    input wire o_conversion_end_irq
);
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_arst_n);
    wire irq = o_conversion_end_irq;
    property p_pulse;
        irq |=> !irq;
    endproperty
    a_pulse: assert property (p_pulse) else $error("irq too long");
    property p_excl;
        !(o_sample && o_hold);
    endproperty
    a_excl: assert property (p_excl) else $error("sample and hold");
    property p_hold;
        $rose(o_hold) |-> $past(o_sample);
    endproperty
    a_hold: assert property (p_hold) else $error("hold without sample");
    property p_msb;
        $rose(o_hold) |-> ##[0:1] (o_tap == 10'h200);
    endproperty
    a_msb: assert property (p_msb) else $error("first tap wrong");
    property p_again;
        irq |-> ##[0:2] o_sample;
    endproperty
    a_again: assert property (p_again) else $error("no restart");
    property p_abort;
        i_wr && o_hold && i_addr != 3'h0 && i_addr <= 3'h3 |-> ##[1:2] o_sample;
    endproperty
    a_abort: assert property (p_abort) else $error("no abort");
    property p_stop;
        i_wr && i_addr == 3'h0 && !i_wdata[7] |-> ##2 (!o_sample && !o_hold && !irq) [*4];
    endproperty
    a_stop: assert property (p_stop) else $error("no halt");
    property p_lj;
        i_rd && i_addr == 3'h4 |=> o_rdata[5:0] == 6'h00;
    endproperty
    a_lj: assert property (p_lj) else $error("low bits set");
endmodule // sasq_chk
bind sasq_top sasq_chk chk_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sample(o_sample),
    .o_hold(o_hold), .o_tap(o_tap), .o_conversion_end_irq(o_conversion_end_irq));

// ===== verification/sasq_top_tb.sv
// self-checking bench for the converter sequencer
`timescale 1ns/1ps
`include "sasq_consts.vh"
module sasq_top_tb;
    reg i_mclk;
    reg i_arst_n;
    reg [2:0] i_addr;
    reg [7:0] i_wdata;
    reg i_wr;
    reg i_rd;
    wire i_cmp_ge;
    wire [7:0] o_rdata;
    wire o_sample;
    wire o_hold;
    wire [9:0] o_tap;
    wire [1:0] o_chan;
    wire o_ref_en;
    wire o_irq;
    reg [39:0] vin;
    reg [7:0] rb;
    reg [2:0] fr;
    integer n_fail;
    integer samples_checked;
    integer n_irq;
    integer k;
    sasq_top #(.SAMPLE_TICKS(4), .TW(16)) dut_u (.i_mclk(i_mclk), .i_arst_n(i_arst_n),
        .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .i_cmp_ge(i_cmp_ge),
        .o_rdata(o_rdata), .o_sample(o_sample), .o_hold(o_hold), .o_tap(o_tap),
        .o_chan(o_chan), .o_ref_en(o_ref_en), .o_conversion_end_irq(o_irq));
    sasq_ana ana_u (.i_mclk(i_mclk), .i_sample(o_sample), .i_hold(o_hold), .i_tap(o_tap),
        .i_chan(o_chan), .i_vin(vin), .o_cmp_ge(i_cmp_ge));
    initial begin
        i_mclk = 1'b0;
        forever #20 i_mclk = ~i_mclk;
    end
    // ----------------------------------------
    // bus tasks and comparison
    // ----------------------------------------
    task chk(input [15:0] exp, input [15:0] got);
        begin
            samples_checked = samples_checked + 1;
            if (got !== exp) begin
                n_fail = n_fail + 1;
                $display("BAD t=%0t exp=%h got=%h", $time, exp, got);
            end
        end
    endtask
    task wr(input [2:0] a, input [7:0] d);
        begin
            @(posedge i_mclk);
            i_addr <= a;
            i_wdata <= d;
            i_wr <= 1'b1;
            @(posedge i_mclk);
            i_wr <= 1'b0;
        end
    endtask
    task rd(input [2:0] a);
        begin
            @(posedge i_mclk);
            i_addr <= a;
            i_rd <= 1'b1;
            @(posedge i_mclk);
            i_rd <= 1'b0;
            #1 rb = o_rdata;
        end
    endtask
    task win(input integer n);
        begin
            n_irq = 0;
            repeat (n) begin
                @(posedge i_mclk);
                #1 n_irq = n_irq + (o_irq === 1'b1);
            end
        end
    endtask
    task res(input [9:0] c);
        reg [7:0] lo;
        begin
            rd(`SASQ_A_RES_LO);
            lo = rb;
            rd(`SASQ_A_RES_HI);
            chk({c, 6'h00}, {rb, lo});
        end
    endtask
    // reference settles before start; first result is then usable
    task go;
        begin
            wr(`SASQ_A_MODE, {2'b00, fr, 3'b001});
            repeat (`SASQ_SETTLE_NS / `SASQ_CLK_NS) @(posedge i_mclk);
            wr(`SASQ_A_MODE, {2'b10, fr, 3'b001});
        end
    endtask
    task close_out;
        begin
            if (n_fail == 0 && samples_checked > 0)
                $display("RESULT: PASS");
            else
                $display("RESULT: FAIL");
            $finish;
        end
    endtask
    initial begin
        repeat (60000) @(posedge i_mclk);
        n_fail = n_fail + 1;
        close_out;
    end
    initial begin
        n_fail = 0;
        samples_checked = 0;
        i_arst_n = 1'b0;
        i_addr = 3'h0;
        i_wdata = 8'h00;
        i_wr = 1'b0;
        i_rd = 1'b0;
        k = $urandom(32'h83358ff8);
        for (k = 0; k < 4; k = k + 1)
            vin[k*10 +: 10] = 10'($urandom % 1020);
        fr = 3'($urandom % 6);
        if (fr > 3'h2)
            fr = fr + 3'h1;
        repeat (3) @(posedge i_mclk);
        i_arst_n <= 1'b1;
        wr(3'h7, 8'hff);
        for (k = 0; k < 8; k = k + 1) begin
            rd(3'(k));
            chk((k == 6) ? 16'h0004 : 16'h0000, {8'h00, rb});
        end
        go;
        for (k = 0; k < 4; k = k + 1) begin
            wr(`SASQ_A_CHAN, 8'(k));
            win(1000);
            chk(16'h0001, 16'(n_irq > 0));
            chk({13'h0, 1'b1, 2'(k)}, {13'h0, o_ref_en, o_chan});
            res(vin[k*10 +: 10]);
        end
        vin[30 +: 10] = ~vin[30 +: 10] - 10'h004;
        win(1000);
        chk(16'h0001, 16'(n_irq > 1));
        res(vin[30 +: 10]);
        wr(`SASQ_A_CHAN, 8'h00);
        go;
        repeat (400) @(posedge i_mclk);
        wr(`SASQ_A_MODE, 8'h01);
        win(1200);
        chk(16'h0000, 16'(n_irq) + {14'h0, o_sample, o_hold});
        for (k = 0; k < 4; k = k + 1) begin
            wr(`SASQ_A_MODE, 8'h01);
            wr(`SASQ_A_PFMODE, {1'b1, k[0], 6'h00});
            wr(`SASQ_A_THRESH, vin[9:2] + 8'(k[1]));
            wr(`SASQ_A_MODE, 8'h81);
            win(1200);
            chk(16'(k[0] == k[1]), 16'(n_irq > 0));
            res(vin[9:0]);
        end
        close_out;
    end
endmodule // sasq_top_tb
